/* iss_pkg.sv */
// constants, types and register map of the instrument state store
// assumes one 100 MHz clock and a single APB master
//
// What this block does
// - six nonvolatile state slots, indexed 0 to 5, each a full configuration
// - power down always writes the live configuration into slot 0
// - a store overwrites the addressed slot silently; slots 6 and 7 error
// - recall of an empty or deleted slot errors and keeps configuration
// - a slot holds every module's configuration words and module types
// - factory reset leaves slots alone; only store, delete, name, power down change them
// - after delivery slot 0 holds power-on setup, slots 1 to 5 empty
// - recall checks module types; a mismatched module gets a card reset instead
// - names are accepted for slots 1 to 5 only, never slot 0
// - name: up to 12 chars, uppercase letter first, then uppercase letters digits underscore
// - an unnamed slot reads back an empty name
// - naming with no name erases the name, keeping state and valid flag
// - remote recall addresses slots by number only
// - delete clears state and valid flag but keeps the name
// - auto recall, default on: power up restores slot 0, else factory reset
// - valid query reads 1 for a stored state, 0 otherwise
// - slot count query always reads 6
package iss_pkg;

    localparam int NSLOT = 6;
    localparam int NMOD  = 3;
    localparam int CFGW  = 32;
    localparam int TYPW  = 4;
    localparam int NAMEC = 12;
    localparam int NAMEW = 96;

    // ------------------------------------------------------------
    // register byte addresses
    // ------------------------------------------------------------
    localparam logic [7:0] A_CMD   = 8'h00;
    localparam logic [7:0] A_STAT  = 8'h04;
    localparam logic [7:0] A_AUTO  = 8'h08;
    localparam logic [7:0] A_NLEN  = 8'h0c;
    localparam logic [7:0] A_NBUF  = 8'h10;
    localparam logic [7:0] A_QSLOT = 8'h1c;
    localparam logic [7:0] A_QNAME = 8'h20;
    localparam logic [7:0] A_CFG   = 8'h2c;
    localparam logic [7:0] A_MTYPE = 8'h38;
    localparam logic [7:0] A_ISTAT = 8'h3c;
    localparam logic [7:0] A_IMASK = 8'h40;

    // ------------------------------------------------------------
    // fields and values after reset
    // ------------------------------------------------------------
    localparam int CMD_OP_LSB   = 0;
    localparam int CMD_SLOT_LSB = 4;
    localparam int ST_AUTO_BIT  = 8;
    localparam int ST_ERR_BIT   = 9;
    localparam int ST_NST_LSB   = 16;
    localparam logic [2:0]  SLOT_COUNT = 3'h6;
    localparam logic        AUTO_RST   = 1'b1;
    localparam logic [5:0]  VALID_RST  = 6'h01;
    localparam logic [31:0] CFG_PON    = 32'h0;
    localparam int IRQ_DONE = 0;
    localparam int IRQ_ERR  = 1;
    localparam int IRQ_CARD = 2;

    typedef enum logic [2:0] {
        OP_NONE, OP_STORE, OP_RECALL, OP_DELETE, OP_NAME, OP_FACTORY
    } iss_op_t;

    typedef struct packed {
        logic [NSLOT-1:0][NMOD-1:0][CFGW-1:0] sl_cfg;
        logic [NSLOT-1:0][NMOD-1:0][TYPW-1:0] sl_typ;
        logic [NSLOT-1:0]                     sl_val;
        logic [NSLOT-1:0][NAMEW-1:0]          sl_name;
        logic [NMOD-1:0][CFGW-1:0]            cfg;
        logic [NMOD-1:0]                      cpor;
        logic                                 auto_on;
        logic [3:0]                           nlen;
        logic [NAMEW-1:0]                     nbuf;
        logic [2:0]                           qslot;
        logic                                 err;
        logic [2:0]                           istat;
        logic [2:0]                           imask;
        logic                                 irq;
        logic [31:0]                          prdata;
        logic                                 pready;
        logic                                 pslverr;
    } iss_state_t;

endpackage

/* iss_name_if.sv */
// carries a candidate slot name to the name checker and its verdict back
// assumes both ends share the block clock
`timescale 1ns/1ns
interface iss_name_if;
    logic [95:0] name;
    logic [3:0]  len;
    logic        ok;
    modport chk (input name, input len, output ok);
    modport usr (output name, output len, input ok);
endinterface

/* iss_name_chk.sv */
// checks a slot name for length and allowed characters
// assumes char 0 sits in bits 7:0; purely combinational
`timescale 1ns/1ns
module iss_name_chk
    import iss_pkg::*;
(
    iss_name_if.chk nif
);

    always_comb begin
        logic [7:0] c;
        logic       good;
        c    = 8'h00;
        good = (nif.len <= 4'(NAMEC));
        for (int k = 0; k < NAMEC; k++) begin
            c = nif.name[8*k +: 8];
            if (k < int'(nif.len)) begin
                if (k == 0) begin
                    good = good & (c >= 8'h41) & (c <= 8'h5a);
                end else begin
                    good = good & (((c >= 8'h41) & (c <= 8'h5a))
                                 | ((c >= 8'h30) & (c <= 8'h39))
                                 | (c == 8'h5f));
                end
            end
        end
        nif.ok = good;
    end

endmodule

/* iss_store.sv */
// six-slot instrument state store with APB register access
// assumes an APB master, synchronous power events and module type inputs
`timescale 1ns/1ns
module iss_store
    import iss_pkg::*;
(
    input  wire logic                       pclk,
    input  wire logic                       presetn,
    input  wire logic                       psel,
    input  wire logic                       penable,
    input  wire logic                       pwrite,
    input  wire logic [7:0]                 paddr,
    input  wire logic [31:0]                pwdata,
    output logic      [31:0]                prdata,
    output logic                            pready,
    output logic                            pslverr,
    input  wire logic                       pwr_down,
    input  wire logic                       pwr_up,
    input  wire logic [NMOD-1:0][TYPW-1:0]  mod_type,
    output logic      [NMOD-1:0][CFGW-1:0]  cfg_out,
    output logic      [NMOD-1:0]            card_power_on_reset,
    output logic                            irq
);

    iss_state_t s_q;
    iss_state_t s_d;

    iss_name_if nif ();

    // ------------------------------------------------------------
    // name checker
    // ------------------------------------------------------------
    assign nif.name = s_q.nbuf;
    assign nif.len  = s_q.nlen;

    iss_name_chk u_chk (
        .nif (nif.chk)
    );

    // ------------------------------------------------------------
    // read decode
    // ------------------------------------------------------------
    logic [31:0] rd_val;
    logic        hit;

    always_comb begin
        logic [7:0] off;
        logic [1:0] wi;
        off    = 8'h00;
        wi     = 2'h0;
        rd_val = 32'h0;
        hit    = (paddr[1:0] == 2'h0);
        if (paddr >= A_NBUF && paddr < A_QSLOT) begin
            off    = paddr - A_NBUF;
            wi     = off[3:2];
            rd_val = s_q.nbuf[32*wi +: 32];
        end else if (paddr >= A_QNAME && paddr < A_CFG) begin
            off    = paddr - A_QNAME;
            wi     = off[3:2];
            // an unnamed slot holds all zero, read as an empty string
            if (s_q.qslot < 3'(NSLOT)) begin
                rd_val = s_q.sl_name[s_q.qslot][32*wi +: 32];
            end
        end else if (paddr >= A_CFG && paddr < A_MTYPE) begin
            off    = paddr - A_CFG;
            wi     = off[3:2];
            rd_val = s_q.cfg[wi];
        end else begin
            unique case (paddr)
                A_CMD: begin
                    rd_val = 32'h0;
                end
                A_STAT: begin
                    rd_val[NSLOT-1:0]          = s_q.sl_val;
                    rd_val[ST_AUTO_BIT]        = s_q.auto_on;
                    rd_val[ST_ERR_BIT]         = s_q.err;
                    rd_val[ST_NST_LSB +: 3]    = SLOT_COUNT;
                end
                A_AUTO: begin
                    rd_val[0] = s_q.auto_on;
                end
                A_NLEN: begin
                    rd_val[3:0] = s_q.nlen;
                end
                A_QSLOT: begin
                    rd_val[2:0] = s_q.qslot;
                end
                A_MTYPE: begin
                    rd_val[NMOD*TYPW-1:0] = mod_type;
                end
                A_ISTAT: begin
                    rd_val[2:0] = s_q.istat;
                end
                A_IMASK: begin
                    rd_val[2:0] = s_q.imask;
                end
                default: begin
                    hit = 1'b0;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        logic        wr;
        iss_op_t     op;
        logic [2:0]  slot;
        logic        rc_go;
        logic [2:0]  rc_slot;
        logic [2:0]  ev;
        logic [2:0]  clr;
        logic [7:0]  off;
        logic [1:0]  wi;
        s_d     = s_q;
        wr      = psel & penable & pwrite & s_q.pready & hit;
        op      = OP_NONE;
        slot    = 3'h0;
        rc_go   = 1'b0;
        rc_slot = 3'h0;
        ev      = 3'h0;
        clr     = 3'h0;
        off     = 8'h00;
        wi      = 2'h0;
        s_d.cpor    = '0;
        s_d.pready  = 1'b0;
        s_d.pslverr = 1'b0;

        // no wait state: setup cycle latches the answer
        if (psel && !penable) begin
            s_d.pready  = 1'b1;
            s_d.prdata  = hit ? rd_val : 32'h0;
            s_d.pslverr = ~hit;
        end

        if (wr) begin
            if (paddr >= A_NBUF && paddr < A_QSLOT) begin
                off = paddr - A_NBUF;
                wi  = off[3:2];
                s_d.nbuf[32*wi +: 32] = pwdata;
            end else if (paddr >= A_CFG && paddr < A_MTYPE) begin
                off = paddr - A_CFG;
                wi  = off[3:2];
                s_d.cfg[wi] = pwdata;
            end else begin
                unique case (paddr)
                    A_CMD: begin
                        // codes past factory reset are reserved and do nothing
                        if (pwdata[CMD_OP_LSB +: 3] <= 3'(OP_FACTORY)) begin
                            op = iss_op_t'(pwdata[CMD_OP_LSB +: 3]);
                        end
                        slot = pwdata[CMD_SLOT_LSB +: 3];
                    end
                    A_AUTO: begin
                        s_d.auto_on = pwdata[0];
                    end
                    A_NLEN: begin
                        s_d.nlen = pwdata[3:0];
                    end
                    A_QSLOT: begin
                        s_d.qslot = pwdata[2:0];
                    end
                    A_ISTAT: begin
                        clr = pwdata[2:0];
                    end
                    A_IMASK: begin
                        s_d.imask = pwdata[2:0];
                    end
                    default: begin
                    end
                endcase
            end
        end

        // --------------------------------------------------------
        // commands
        // --------------------------------------------------------
        if (op != OP_NONE) begin
            ev[IRQ_DONE] = 1'b1;
            s_d.err      = 1'b0;
        end
        unique case (op)
            OP_STORE: begin
                if (slot < 3'(NSLOT)) begin
                    s_d.sl_cfg[slot] = s_q.cfg;
                    s_d.sl_typ[slot] = mod_type;
                    s_d.sl_val[slot] = 1'b1;
                end else begin
                    s_d.err = 1'b1;
                end
            end
            OP_RECALL: begin
                if (slot < 3'(NSLOT) && s_q.sl_val[slot]) begin
                    rc_go   = 1'b1;
                    rc_slot = slot;
                end else begin
                    s_d.err = 1'b1;
                end
            end
            OP_DELETE: begin
                if (slot < 3'(NSLOT)) begin
                    s_d.sl_cfg[slot] = '0;
                    s_d.sl_typ[slot] = '0;
                    s_d.sl_val[slot] = 1'b0;
                end else begin
                    s_d.err = 1'b1;
                end
            end
            OP_NAME: begin
                if (slot == 3'h0 || slot >= 3'(NSLOT)) begin
                    s_d.err = 1'b1;
                end else if (s_q.nlen == 4'h0) begin
                    s_d.sl_name[slot] = '0;
                end else if (nif.ok) begin
                    for (int k = 0; k < NAMEC; k++) begin
                        s_d.sl_name[slot][8*k +: 8] =
                            (k < int'(s_q.nlen)) ? s_q.nbuf[8*k +: 8] : 8'h00;
                    end
                end else begin
                    s_d.err = 1'b1;
                end
            end
            OP_FACTORY: begin
                // slots are untouched, only the live setup reverts
                for (int m = 0; m < NMOD; m++) begin
                    s_d.cfg[m] = CFG_PON;
                end
            end
            default: begin
            end
        endcase
        if (s_d.err && op != OP_NONE) begin
            ev[IRQ_ERR] = 1'b1;
        end

        // --------------------------------------------------------
        // power events, taking precedence over a same-cycle command
        // --------------------------------------------------------
        if (pwr_down) begin
            s_d.sl_cfg[0] = s_q.cfg;
            s_d.sl_typ[0] = mod_type;
            s_d.sl_val[0] = 1'b1;
        end
        if (pwr_up) begin
            rc_go = 1'b0;
            if (s_q.auto_on && s_q.sl_val[0]) begin
                rc_go   = 1'b1;
                rc_slot = 3'h0;
            end else begin
                for (int m = 0; m < NMOD; m++) begin
                    s_d.cfg[m] = CFG_PON;
                end
            end
        end

        // --------------------------------------------------------
        // recall with module type check
        // --------------------------------------------------------
        if (rc_go) begin
            for (int m = 0; m < NMOD; m++) begin
                if (s_q.sl_typ[rc_slot][m] == mod_type[m]) begin
                    s_d.cfg[m] = s_q.sl_cfg[rc_slot][m];
                end else begin
                    // a foreign card would misread a saved setup
                    s_d.cfg[m]  = CFG_PON;
                    s_d.cpor[m] = 1'b1;
                    ev[IRQ_CARD] = 1'b1;
                end
            end
        end

        // --------------------------------------------------------
        // interrupt: a same-cycle event beats its clear
        // --------------------------------------------------------
        s_d.istat = (s_q.istat & ~clr) | ev;
        s_d.irq   = |(s_d.istat & s_d.imask);
    end

    // ------------------------------------------------------------
    // state register
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_q         <= '0;
            s_q.auto_on <= AUTO_RST;
            s_q.sl_val  <= VALID_RST;
        end else begin
            s_q <= s_d;
        end
    end

    assign prdata              = s_q.prdata;
    assign pready              = s_q.pready;
    assign pslverr             = s_q.pslverr;
    assign cfg_out             = s_q.cfg;
    assign card_power_on_reset = s_q.cpor;
    assign irq                 = s_q.irq;

endmodule

/* iss_store_props.sv */
// port assertions for the instrument state store
// assumes a bind to iss_store and the single pclk domain
`timescale 1ns/1ns
module iss_store_props
    import iss_pkg::*;
(
    input wire logic                      pclk,
    input wire logic                      presetn,
    input wire logic                      psel,
    input wire logic                      penable,
    input wire logic                      pwrite,
    input wire logic [7:0]                paddr,
    input wire logic [31:0]               prdata,
    input wire logic                      pready,
    input wire logic                      pslverr,
    input wire logic                      pwr_up,
    input wire logic [NMOD-1:0][TYPW-1:0] mod_type,
    input wire logic [NMOD-1:0][CFGW-1:0] cfg_out,
    input wire logic [NMOD-1:0]           card_power_on_reset,
    input wire logic                      irq
);
    // registered causes, so a change one edge later can be tied to them
    logic wr_q;
    logic cause_q;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wr_q    <= 1'b0;
            cause_q <= 1'b0;
        end else begin
            wr_q    <= psel & penable & pwrite & pready;
            cause_q <= pwr_up | (psel & penable & pwrite & pready);
        end
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_access;
        psel && penable && pready;
    endsequence
    sequence s_read(logic [7:0] a);
        s_access ##0 (!pwrite && paddr == a);
    endsequence
    a_ready_after_setup: assert property (s_setup |=> pready)
        else $error("no ready after setup");
    a_ready_single: assert property (pready |=> !pready)
        else $error("ready held too long");
    a_error_with_ready: assert property (pslverr |-> pready)
        else $error("error outside access");
    a_bad_align: assert property (s_access ##0 (paddr[1:0] != 2'h0) |-> pslverr)
        else $error("unaligned access accepted");
    a_count_six: assert property (s_read(A_STAT) |-> prdata[18:16] == SLOT_COUNT)
        else $error("slot count not six");
    a_cmd_reads_zero: assert property (s_read(A_CMD) |-> prdata == 32'h0)
        else $error("command word read back");
    a_types_readback: assert property (s_read(A_MTYPE) |-> prdata[11:0] == $past(mod_type))
        else $error("installed types misread");
    a_cfg_has_cause: assert property ($changed(cfg_out) |-> cause_q)
        else $error("config changed without cause");
    a_card_reset_cause: assert property (|card_power_on_reset |-> cause_q)
        else $error("card reset without recall");
    a_irq_fall_cause: assert property ($fell(irq) |-> wr_q || $past(wr_q))
        else $error("irq fell without write");
endmodule

/* iss_apb_host.sv */
// apb command source standing in for the command interpreter
// assumes the same pclk as the state store
`timescale 1ns/1ns
module iss_apb_host (
    input  wire logic        pclk,
    output logic             psel,
    output logic             penable,
    output logic             pwrite,
    output logic [7:0]       paddr,
    output logic [31:0]      pwdata,
    input  wire logic [31:0] prdata,
    input  wire logic        pready,
    input  wire logic        pslverr
);
    initial begin
        psel    = 1'b0;
        penable = 1'b0;
        pwrite  = 1'b0;
        paddr   = 8'h00;
        pwdata  = 32'h0;
    end
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                        output logic [31:0] q, output logic e);
        @(posedge pclk);
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        // released lines flip so a stale value cannot look valid
        paddr   <= ~a;
        pwdata  <= ~d;
    endtask
endmodule

/* iss_store_test.sv */
// bench for the state store: the host model drives apb, tasks judge
// assumes iss_apb_host and iss_store_props compiled before it
`timescale 1ns/1ns
module iss_store_test
    import iss_pkg::*;
;
    logic                      pclk     = 1'b0;
    logic                      presetn  = 1'b0;
    logic                      pwr_down = 1'b0;
    logic                      pwr_up   = 1'b0;
    logic [NMOD-1:0][TYPW-1:0] mod_type = 12'h321;
    logic [NMOD-1:0][CFGW-1:0] cfg_out;
    logic [NMOD-1:0]           card_power_on_reset;
    logic [31:0]               pwdata, prdata;
    logic [7:0]                paddr;
    logic                      psel, penable, pwrite, pready, pslverr, irq;
    int                        fails, samples_checked, cycles;
    // first two names are legal, the rest too long, digit first, blank
    logic [95:0]               nm [5] = '{96'h4241, 96'h395f4a49_48474645_44434241,
                                          96'h395f4a49_48474645_44434241, 96'h4131, 96'h422041};
    logic [3:0]                ln [5] = '{4'h2, 4'hc, 4'hd, 4'h2, 4'h3};
    iss_apb_host host (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
    iss_store DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .pwr_down(pwr_down), .pwr_up(pwr_up), .mod_type(mod_type),
        .cfg_out(cfg_out), .card_power_on_reset(card_power_on_reset), .irq(irq));
    always #5 pclk = ~pclk;
    always @(posedge pclk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            fails = fails + 1;
            summarize();
        end
    end
    task automatic summarize();
        $display("checks %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task automatic chk(input logic [95:0] got, input logic [95:0] exp, input string m);
        samples_checked++;
        if (got !== exp) begin
            fails++;
            $display("unexpected at %0t: %s, got %h want %h", $time, m, got, exp);
        end
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] msk, exp, input string m);
        logic [31:0] q;
        logic        e;
        host.xfer(1'b0, a, 32'h0, q, e);
        chk(q & msk, exp, m);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        logic        e;
        host.xfer(1'b1, a, d, q, e);
    endtask
    task automatic cmd(input iss_op_t op, input logic [2:0] s);
        wr(A_CMD, {25'h0, s, 1'b0, op});
    endtask
    function automatic logic [95:0] pat(input logic [31:0] b);
        return {b + 32'h2, b + 32'h1, b};
    endfunction
    task automatic load(input logic [31:0] b);
        for (int m = 0; m < NMOD; m++) wr(A_CFG + 8'(4 * m), b + 32'(m));
    endtask
    task automatic name(input logic [2:0] s, input logic [95:0] n, input logic [3:0] l);
        for (int w = 0; w < 3; w++) wr(A_NBUF + 8'(4 * w), n[32*w +: 32]);
        wr(A_NLEN, {28'h0, l});
        cmd(OP_NAME, s);
    endtask
    task automatic pulse(input logic dn);
        @(posedge pclk);
        if (dn) pwr_down <= 1'b1;
        else pwr_up <= 1'b1;
        @(posedge pclk);
        pwr_down <= 1'b0;
        pwr_up   <= 1'b0;
        #1;
    endtask
    task automatic t_store();
        rdc(A_STAT, 32'hffff_ffff, 32'h0006_0101, "status after reset");
        rdc(A_CMD, 32'hffff_ffff, 32'h0, "command reads zero");
        load(32'ha000_0000);
        cmd(OP_STORE, 3'h3);
        load(32'hb000_0000);
        cmd(OP_STORE, 3'h3);
        rdc(A_STAT, 32'h23f, 32'h009, "overwrite store");
        cmd(OP_FACTORY, 3'h0);
        #1;
        chk(cfg_out, 96'h0, "factory config");
        rdc(A_STAT, 32'h03f, 32'h009, "factory keeps slots");
        cmd(OP_RECALL, 3'h3);
        #1;
        chk(cfg_out, pat(32'hb000_0000), "recall latest store");
        chk(card_power_on_reset, 3'h0, "types match");
        cmd(OP_DELETE, 3'h7);
        rdc(A_STAT, 32'h23f, 32'h209, "delete slot seven");
        cmd(OP_STORE, 3'h3);
        cmd(OP_RECALL, 3'h4);
        rdc(A_STAT, 32'h200, 32'h200, "empty recall");
        chk(cfg_out, pat(32'hb000_0000), "config kept");
        cmd(OP_RECALL, 3'h6);
        rdc(A_STAT, 32'h200, 32'h200, "slot six");
        cmd(OP_RECALL, 3'h0);
        #1;
        chk(card_power_on_reset, 3'h7, "power-on types differ");
        $display("test store done");
    endtask
    task automatic t_names();
        logic [31:0] good;
        good = 32'h0;
        cmd(OP_STORE, 3'h1);
        for (int i = 0; i < 5; i++) begin
            name(3'h1, nm[i], ln[i]);
            if (i < 2) good = nm[i][31:0];
            rdc(A_STAT, 32'h200, (i > 1) ? 32'h200 : 32'h0, "name verdict");
            wr(A_QSLOT, 32'h1);
            rdc(A_QNAME, 32'hffff_ffff, good, "name readback");
        end
        name(3'h0, nm[0], 4'h2);
        rdc(A_STAT, 32'h200, 32'h200, "slot 0 name");
        name(3'h1, 96'h0, 4'h0);
        rdc(A_QNAME, 32'hffff_ffff, 32'h0, "erased name");
        rdc(A_STAT, 32'h202, 32'h002, "valid kept");
        name(3'h2, nm[0], 4'h2);
        cmd(OP_STORE, 3'h2);
        cmd(OP_DELETE, 3'h2);
        rdc(A_STAT, 32'h23f, 32'h00b, "delete clears valid");
        wr(A_QSLOT, 32'h2);
        rdc(A_QNAME, 32'hffff_ffff, 32'h4241, "delete keeps name");
        cmd(OP_RECALL, 3'h2);
        rdc(A_STAT, 32'h200, 32'h200, "deleted recall");
        $display("test names done");
    endtask
    task automatic t_power();
        load(32'hc000_0000);
        cmd(OP_STORE, 3'h0);
        load(32'hd000_0000);
        pulse(1'b1);
        cmd(OP_FACTORY, 3'h0);
        pulse(1'b0);
        chk(cfg_out, pat(32'hd000_0000), "power down state");
        @(posedge pclk);
        mod_type <= 12'h301;
        pulse(1'b0);
        chk(card_power_on_reset, 3'h2, "changed module");
        rdc(A_MTYPE, 32'hfff, 32'h301, "installed types");
        wr(A_AUTO, 32'h0);
        pulse(1'b0);
        chk(cfg_out, 96'h0, "auto off");
        rdc(A_AUTO, 32'h1, 32'h0, "auto reads back");
        $display("test power done");
    endtask
    task automatic t_irq();
        logic [31:0] q;
        logic        e;
        wr(A_ISTAT, 32'h7);
        wr(A_IMASK, 32'h2);
        cmd(OP_STORE, 3'h4);
        rdc(A_ISTAT, 32'h7, 32'h1, "done only");
        chk(irq, 1'b0, "done masked");
        cmd(OP_RECALL, 3'h5);
        rdc(A_ISTAT, 32'h7, 32'h3, "error flagged");
        chk(irq, 1'b1, "irq raised");
        wr(A_ISTAT, 32'h2);
        rdc(A_ISTAT, 32'h7, 32'h1, "error cleared");
        chk(irq, 1'b0, "irq dropped");
        host.xfer(1'b0, 8'h80, 32'h0, q, e);
        chk({e, q}, 33'h1_0000_0000, "unmapped read");
        host.xfer(1'b1, 8'h06, 32'h0, q, e);
        chk(e, 1'b1, "unaligned write");
        wr(A_ISTAT, 32'h7);
        cmd(OP_RECALL, 3'h0);
        rdc(A_ISTAT, 32'h7, 32'h5, "card reset event");
        $display("test irq done");
    endtask
    initial begin
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        t_store();
        t_names();
        t_power();
        t_irq();
        summarize();
    end
endmodule
bind iss_store iss_store_props u_props (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .pwr_up(pwr_up), .mod_type(mod_type), .cfg_out(cfg_out),
    .card_power_on_reset(card_power_on_reset), .irq(irq));
